// [rtl/mafd_map.vh]
/*
  Constants of the move/add field datapath: register offsets, reset values,
  instruction field positions, opcodes and register-file indices.
  Assumes plain Verilog-2005 and inclusion by bare name.
*/
`ifndef MAFD_MAP_VH
`define MAFD_MAP_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define MAFD_OFS_INSTR 5'h00
`define MAFD_OFS_STATUS 5'h04
`define MAFD_OFS_REGSEL 5'h08
`define MAFD_OFS_REGDATA 5'h0C
`define MAFD_OFS_LATCH 5'h10

// ****************************************
// Reset values
// ****************************************
`define MAFD_RST_INSTR 16'h0000
`define MAFD_RST_REGSEL 4'h0
`define MAFD_RST_BYTE 8'h00

// ****************************************
// Instruction fields, bit numbers as in the 16-bit word, opcode in bits 15:13
// ****************************************
`define MAFD_OP_HI 15
`define MAFD_OP_LO 13
`define MAFD_SRC_HI 12
`define MAFD_SRC_LO 8
`define MAFD_RL_HI 7
`define MAFD_RL_LO 5
`define MAFD_DST_HI 4
`define MAFD_DST_LO 0
`define MAFD_OPC_MOVE 3'h0
`define MAFD_OPC_ADD 3'h1
`define MAFD_ADDR_OFS 3'h7

// ****************************************
// Register-file indices and status bits
// ****************************************
`define MAFD_IDX_AUX 4'h0
`define MAFD_IDX_OVF 4'h8
`define MAFD_ST_BUSY 0
`define MAFD_ST_OVF 1
`define MAFD_ST_BADOP 2

// ****************************************
// AXI responses
// ****************************************
`define MAFD_RESP_OKAY 2'h0
`define MAFD_RESP_SLVERR 2'h2

`endif

// [rtl/mafd_field_unit.v]
/*
  Combinational field unit: rotate, mask, add, shift and merge for one
  instruction. Assumes the caller supplies the source register, the addend
  register and the port data latched in the input phase.
*/
`timescale 1ns/1ps
`include "mafd_map.vh"

module mafd_field_unit (
  input wire [15:0] i_instr,
  input wire [7:0] i_src_reg,
  input wire [7:0] i_aux,
  input wire [7:0] i_latch,
  output reg [7:0] o_value,
  output reg [7:0] o_bus_data,
  output reg o_ovf
);

  // ****************************************
  // Helpers
  // ****************************************
  function [7:0] rotr;
    input [7:0] v;
    input [2:0] n;
    reg [15:0] t;
    begin
      t = {v, v} >> n;
      rotr = t[7:0];
    end
  endfunction

  function [7:0] lmask;
    input [2:0] len;
    begin
      lmask = (len == 3'h0) ? 8'hFF : ~(8'hFF << len);
    end
  endfunction

  // ****************************************
  // Datapath
  // ****************************************
  reg [2:0] op;
  reg [4:0] src;
  reg [2:0] rl;
  reg [4:0] dst;
  reg s_bus;
  reg d_bus;
  reg full;
  reg [7:0] m;
  reg [7:0] base;
  reg [8:0] sum;
  reg [7:0] fm;
  reg [7:0] fld;

  always @* begin
    op = i_instr[`MAFD_OP_HI:`MAFD_OP_LO];
    src = i_instr[`MAFD_SRC_HI:`MAFD_SRC_LO];
    rl = i_instr[`MAFD_RL_HI:`MAFD_RL_LO];
    dst = i_instr[`MAFD_DST_HI:`MAFD_DST_LO];
    s_bus = src[4];
    d_bus = dst[4];
    full = (s_bus && d_bus && (src[3] != dst[3]));
    m = full ? 8'hFF : lmask(rl);
    if (s_bus) begin
      base = rotr(i_latch, src[2:0]) & m;
    end else if (d_bus) begin
      base = i_src_reg;
    end else begin
      base = rotr(i_src_reg, rl);
    end
    sum = {1'b0, base} + {1'b0, (op == `MAFD_OPC_ADD) ? i_aux : 8'h00};
    o_value = sum[7:0];
    o_ovf = (op == `MAFD_OPC_ADD) && sum[8];
    fm = m << dst[2:0];
    fld = (sum[7:0] & m) << dst[2:0];
    o_bus_data = (i_latch & ~fm) | fld;
  end

endmodule // mafd_field_unit

// [rtl/mafd_datapath.v]
/*
  Move/add field datapath with an AXI4-Lite register port and a two-bank
  I/O bus. Assumes bus pins are synchronous to i_ref_clk and that software
  loads the working registers before launching an instruction.
*/
`timescale 1ns/1ps
`include "mafd_map.vh"

module mafd_datapath (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire [4:0] i_axi_awaddr,
  input wire i_axi_awvalid,
  output reg o_axi_awready,
  input wire [31:0] i_axi_wdata,
  input wire [3:0] i_axi_wstrb,
  input wire i_axi_wvalid,
  output reg o_axi_wready,
  output reg [1:0] o_axi_bresp,
  output reg o_axi_bvalid,
  input wire i_axi_bready,
  input wire [4:0] i_axi_araddr,
  input wire i_axi_arvalid,
  output reg o_axi_arready,
  output reg [31:0] o_axi_rdata,
  output reg [1:0] o_axi_rresp,
  output reg o_axi_rvalid,
  input wire i_axi_rready,
  input wire [7:0] i_interface_vector_bus,
  output reg [7:0] o_interface_vector_bus,
  output reg o_interface_vector_bus_oe,
  output reg o_select_command_strobe,
  output reg o_write_command_strobe,
  output reg o_left_bank_enable_n,
  output reg o_right_bank_enable_n
);

  // ****************************************
  // Sequencer states
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_INP = 2'h1;
  localparam [1:0] ST_EXE = 2'h2;
  localparam [1:0] ST_OUT = 2'h3;

  function [31:0] bmerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer k;
    begin
      bmerge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          bmerge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  function is_mapped;
    input [4:0] a;
    begin
      is_mapped = (a == `MAFD_OFS_INSTR) || (a == `MAFD_OFS_STATUS) || (a == `MAFD_OFS_REGSEL) ||
                  (a == `MAFD_OFS_REGDATA) || (a == `MAFD_OFS_LATCH);
    end
  endfunction

  // Byte lanes inside a word are ignored, so both address channels decode the aligned word.
  function [4:0] word_addr;
    input [4:0] a;
    begin
      word_addr = {a[4:2], 2'b00};
    end
  endfunction

  // ****************************************
  // State
  // ****************************************
  reg [1:0] state_r;
  reg [15:0] instr_r;
  reg [3:0] regsel_r;
  reg [7:0] latch_r;
  reg ovf_last_r;
  reg badop_r;
  reg [7:0] rf_r [0:15];
  reg aw_got_r;
  reg w_got_r;
  reg [4:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  integer i;

  wire [2:0] op = instr_r[`MAFD_OP_HI:`MAFD_OP_LO];
  wire [4:0] src = instr_r[`MAFD_SRC_HI:`MAFD_SRC_LO];
  wire [4:0] dst = instr_r[`MAFD_DST_HI:`MAFD_DST_LO];
  wire s_bus = src[4];
  wire d_bus = dst[4];
  wire d_addr = !d_bus && (dst[2:0] == `MAFD_ADDR_OFS);
  wire op_ok = (op == `MAFD_OPC_MOVE) || (op == `MAFD_OPC_ADD);
  wire [7:0] fu_value;
  wire [7:0] fu_bus;
  wire fu_ovf;

  mafd_field_unit u_field (
    .i_instr(instr_r),
    .i_src_reg(rf_r[src[3:0]]),
    .i_aux(rf_r[`MAFD_IDX_AUX]),
    .i_latch(latch_r),
    .o_value(fu_value),
    .o_bus_data(fu_bus),
    .o_ovf(fu_ovf)
  );

  // ****************************************
  // Bus slave handshake
  // ****************************************
  wire aw_take = i_axi_awvalid && o_axi_awready;
  wire w_take = i_axi_wvalid && o_axi_wready;
  wire wr_go = aw_got_r && w_got_r && !o_axi_bvalid;
  wire busy = (state_r != ST_IDLE);
  wire launch = wr_go && (awaddr_r == `MAFD_OFS_INSTR) && !busy;
  wire [31:0] instr_w = bmerge({16'h0000, instr_r}, wdata_r, wstrb_r);
  wire [31:0] sel_w = bmerge({28'h0000000, regsel_r}, wdata_r, wstrb_r);
  wire [31:0] dat_w = bmerge({24'h000000, rf_r[regsel_r]}, wdata_r, wstrb_r);

  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_axi_awready <= 1'b0;
      o_axi_wready <= 1'b0;
      o_axi_bvalid <= 1'b0;
      o_axi_bresp <= `MAFD_RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      o_axi_awready <= i_axi_awvalid && !aw_got_r && !o_axi_awready && !o_axi_bvalid;
      o_axi_wready <= i_axi_wvalid && !w_got_r && !o_axi_wready && !o_axi_bvalid;
      if (aw_take) begin
        aw_got_r <= 1'b1;
        awaddr_r <= word_addr(i_axi_awaddr);
      end
      if (w_take) begin
        w_got_r <= 1'b1;
        wdata_r <= i_axi_wdata;
        wstrb_r <= i_axi_wstrb;
      end
      if (wr_go) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        o_axi_bvalid <= 1'b1;
        o_axi_bresp <= is_mapped(awaddr_r) ? `MAFD_RESP_OKAY : `MAFD_RESP_SLVERR;
      end else if (o_axi_bvalid && i_axi_bready) begin
        o_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reads are side-effect free, so a one-cycle answer keeps the port simple.
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_axi_arready <= 1'b0;
      o_axi_rvalid <= 1'b0;
      o_axi_rdata <= 32'h00000000;
      o_axi_rresp <= `MAFD_RESP_OKAY;
    end else begin
      o_axi_arready <= i_axi_arvalid && !o_axi_arready && !o_axi_rvalid;
      if (i_axi_arvalid && o_axi_arready) begin
        o_axi_rvalid <= 1'b1;
        o_axi_rresp <= is_mapped(word_addr(i_axi_araddr)) ? `MAFD_RESP_OKAY : `MAFD_RESP_SLVERR;
        case (word_addr(i_axi_araddr))
          `MAFD_OFS_INSTR: o_axi_rdata <= {16'h0000, instr_r};
          `MAFD_OFS_STATUS: o_axi_rdata <= {29'h0000000, badop_r, ovf_last_r, busy};
          `MAFD_OFS_REGSEL: o_axi_rdata <= {28'h0000000, regsel_r};
          `MAFD_OFS_REGDATA: o_axi_rdata <= {24'h000000, rf_r[regsel_r]};
          `MAFD_OFS_LATCH: o_axi_rdata <= {24'h000000, latch_r};
          default: o_axi_rdata <= 32'h00000000;
        endcase
      end else if (o_axi_rvalid && i_axi_rready) begin
        o_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // Instruction sequencer and pins
  // ****************************************
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= ST_IDLE;
      instr_r <= `MAFD_RST_INSTR;
      regsel_r <= `MAFD_RST_REGSEL;
      latch_r <= `MAFD_RST_BYTE;
      ovf_last_r <= 1'b0;
      badop_r <= 1'b0;
      o_interface_vector_bus <= 8'h00;
      o_interface_vector_bus_oe <= 1'b0;
      o_select_command_strobe <= 1'b0;
      o_write_command_strobe <= 1'b0;
      o_left_bank_enable_n <= 1'b1;
      o_right_bank_enable_n <= 1'b1;
    end else begin
      if (wr_go && (awaddr_r == `MAFD_OFS_REGSEL)) begin
        regsel_r <= sel_w[3:0];
      end
      case (state_r)
        ST_IDLE: begin
          if (launch) begin
            instr_r <= instr_w[15:0];
            state_r <= ST_INP;
          end
        end
        ST_INP: begin
          // Only ops that read a port open a bank; the source bank wins over the destination.
          if (op_ok && (s_bus || d_bus)) begin
            o_left_bank_enable_n <= s_bus ? src[3] : dst[3];
            o_right_bank_enable_n <= s_bus ? !src[3] : !dst[3];
          end
          state_r <= ST_EXE;
        end
        ST_EXE: begin
          badop_r <= !op_ok;
          if (!o_left_bank_enable_n || !o_right_bank_enable_n) begin
            latch_r <= i_interface_vector_bus;
          end
          o_left_bank_enable_n <= 1'b1;
          o_right_bank_enable_n <= 1'b1;
          state_r <= ST_OUT;
        end
        ST_OUT: begin
          if (o_interface_vector_bus_oe) begin
            o_interface_vector_bus_oe <= 1'b0;
            o_select_command_strobe <= 1'b0;
            o_write_command_strobe <= 1'b0;
            o_left_bank_enable_n <= 1'b1;
            o_right_bank_enable_n <= 1'b1;
            state_r <= ST_IDLE;
          end else if (op_ok && (d_bus || d_addr)) begin
            o_interface_vector_bus_oe <= 1'b1;
            o_interface_vector_bus <= d_addr ? fu_value : fu_bus;
            o_select_command_strobe <= d_addr;
            o_write_command_strobe <= !d_addr;
            o_left_bank_enable_n <= dst[3];
            o_right_bank_enable_n <= !dst[3];
          end else begin
            state_r <= ST_IDLE;
          end
          if (!o_interface_vector_bus_oe && op_ok) begin
            ovf_last_r <= fu_ovf;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Working registers
  // ****************************************
  // Flops with no reset value would leave the addend undefined, so all are cleared.
  always @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (i = 0; i < 16; i = i + 1) begin
        rf_r[i] <= `MAFD_RST_BYTE;
      end
    end else begin
      if (wr_go && (awaddr_r == `MAFD_OFS_REGDATA) && !busy) begin
        rf_r[regsel_r] <= dat_w[7:0];
      end
      if ((state_r == ST_OUT) && !o_interface_vector_bus_oe && op_ok) begin
        if (op == `MAFD_OPC_ADD) begin
          rf_r[`MAFD_IDX_OVF] <= {7'h00, fu_ovf};
        end
        // Destination written last so it wins when it is also the flag register.
        if (!d_bus) begin
          rf_r[dst[3:0]] <= fu_value;
        end
      end
    end
  end

endmodule // mafd_datapath

// [verification/mafd_datapath_chk.sv]
/* Checker for the I/O bus strobes and the response channels.
   Assumes it is bound to mafd_datapath. */
`timescale 1ns/1ps
module mafd_datapath_chk (
  input wire i_ref_clk,
  input wire i_arst_n,
  input wire o_axi_bvalid,
  input wire i_axi_bready,
  input wire o_axi_rvalid,
  input wire i_axi_rready,
  input wire [1:0] o_axi_bresp,
  input wire o_interface_vector_bus_oe,
  input wire o_select_command_strobe,
  input wire o_write_command_strobe,
  input wire o_left_bank_enable_n,
  input wire o_right_bank_enable_n
);
  wire oe = o_interface_vector_bus_oe;
  wire sc = o_select_command_strobe;
  wire wc = o_write_command_strobe;
  wire lb = o_left_bank_enable_n;
  wire rb = o_right_bank_enable_n;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  property p_sc; sc |-> oe && !wc && (lb != rb); endproperty
  a_sc: assert property (p_sc) else $error("select strobe without one bank");
  property p_wc; wc |-> oe && !sc && (lb != rb); endproperty
  a_wc: assert property (p_wc) else $error("write strobe without one bank");
  property p_oe; oe |-> sc || wc; endproperty
  a_oe: assert property (p_oe) else $error("bus driven without strobe");
  property p_one; oe |=> !oe [*3]; endproperty
  a_one: assert property (p_one) else $error("output phase too long");
  property p_lat; wc |-> $past(lb, 2) != $past(rb, 2); endproperty
  a_lat: assert property (p_lat) else $error("write without input phase");
  property p_both; !(!lb && !rb); endproperty
  a_both: assert property (p_both) else $error("both banks enabled");
  property p_inp; (!lb || !rb) && !oe |=> lb && rb; endproperty
  a_inp: assert property (p_inp) else $error("input enable held");
  property p_bq; o_axi_bvalid && i_axi_bready |=> !o_axi_bvalid; endproperty
  a_bq: assert property (p_bq) else $error("write response not cleared");
  property p_rq; o_axi_rvalid && i_axi_rready |=> !o_axi_rvalid; endproperty
  a_rq: assert property (p_rq) else $error("read response not cleared");
  c_addr: cover property (sc);
  c_write: cover property (wc);
  c_err: cover property (o_axi_bvalid && o_axi_bresp == 2'h2);
endmodule // mafd_datapath_chk

bind mafd_datapath mafd_datapath_chk u_chk (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
  .o_axi_bvalid(o_axi_bvalid), .i_axi_bready(i_axi_bready), .o_axi_rvalid(o_axi_rvalid),
  .i_axi_rready(i_axi_rready), .o_axi_bresp(o_axi_bresp), .o_interface_vector_bus_oe(o_interface_vector_bus_oe),
  .o_select_command_strobe(o_select_command_strobe), .o_write_command_strobe(o_write_command_strobe),
  .o_left_bank_enable_n(o_left_bank_enable_n), .o_right_bank_enable_n(o_right_bank_enable_n));

// [verification/mafd_port_model.sv]
/* Model of the I/O ports on both banks of the I/O bus.
   Assumes the bench presets port contents through i_load. */
`timescale 1ns/1ps
module mafd_port_model (
  input wire i_ref_clk,
  input wire i_load,
  input wire [7:0] i_left_val,
  input wire [7:0] i_right_val,
  input wire [7:0] i_bus_out,
  input wire i_oe,
  input wire i_wc,
  input wire i_left_en_n,
  input wire i_right_en_n,
  output wire [7:0] o_bus_in,
  output reg [7:0] o_left_port,
  output reg [7:0] o_right_port
);
  reg [7:0] last_r = 8'h00;
  // An idle bus shows the inverse of its last value, so stale data never passes as fresh.
  assign o_bus_in = !i_left_en_n ? o_left_port : (!i_right_en_n ? o_right_port : ~last_r);
  always @(posedge i_ref_clk) begin
    last_r <= o_bus_in;
    if (i_load) begin
      o_left_port <= i_left_val;
      o_right_port <= i_right_val;
    end else if (i_oe && i_wc && !i_left_en_n) begin
      o_left_port <= i_bus_out;
    end else if (i_oe && i_wc && !i_right_en_n) begin
      o_right_port <= i_bus_out;
    end
  end
endmodule // mafd_port_model

// [verification/move_add_field_datapath_tb_top.sv]
/* Bench for the move/add field datapath, one task per scenario.
   Assumes the register map header and the port model. */
`timescale 1ns/1ps
`include "mafd_map.vh"
module move_add_field_datapath_tb_top;
  reg clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0, load = 1'b0;
  reg [4:0] awa = 5'h00, ara = 5'h00;
  reg [31:0] wd = 32'h0, d;
  reg [7:0] lv = 8'h00, rv = 8'h00;
  reg [10:0] cap = 11'h000;
  reg [1:0] rsp;
  wire awr, wr_r, bv, arr, rvl, oe, sc, wc, lb_n, rb_n;
  wire [1:0] br, rr;
  wire [31:0] rdat;
  wire [7:0] bin, bout, lp, rp;
  integer num_errors = 0, checked = 0;
  mafd_datapath dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_axi_awaddr(awa), .i_axi_awvalid(awv),
    .o_axi_awready(awr), .i_axi_wdata(wd), .i_axi_wstrb(4'hF), .i_axi_wvalid(wv), .o_axi_wready(wr_r),
    .o_axi_bresp(br), .o_axi_bvalid(bv), .i_axi_bready(brdy), .i_axi_araddr(ara), .i_axi_arvalid(arv),
    .o_axi_arready(arr), .o_axi_rdata(rdat), .o_axi_rresp(rr), .o_axi_rvalid(rvl), .i_axi_rready(rrdy),
    .i_interface_vector_bus(bin), .o_interface_vector_bus(bout), .o_interface_vector_bus_oe(oe),
    .o_select_command_strobe(sc), .o_write_command_strobe(wc), .o_left_bank_enable_n(lb_n),
    .o_right_bank_enable_n(rb_n));
  mafd_port_model ports (.i_ref_clk(clk), .i_load(load), .i_left_val(lv), .i_right_val(rv), .i_bus_out(bout),
    .i_oe(oe), .i_wc(wc), .i_left_en_n(lb_n), .i_right_en_n(rb_n), .o_bus_in(bin), .o_left_port(lp),
    .o_right_port(rp));
  initial forever #4 clk = ~clk;
  always @(posedge clk) if (oe) cap <= {sc, lb_n, rb_n, bout};
  // ****************************************
  // Common tasks
  // ****************************************
  task stop_test;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0s expected %0h seen %0h", n, e, g);
      end
    end
  endtask
  task tmo;
    begin
      chk("handshake", 32'h1, 32'h0);
      stop_test;
    end
  endtask
  task wr(input [4:0] a, input [31:0] v);
    integer n;
    begin
      @(posedge clk);
      awa <= a;
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      brdy <= 1'b1;
      for (n = 0; !bv; n = n + 1) begin
        @(posedge clk);
        if (awr) awv <= 1'b0;
        if (wr_r) wv <= 1'b0;
        if (n > 50) tmo;
      end
      rsp = br;
      brdy <= 1'b0;
    end
  endtask
  task rd(input [4:0] a);
    integer n;
    begin
      @(posedge clk);
      ara <= a;
      arv <= 1'b1;
      rrdy <= 1'b1;
      for (n = 0; !rvl; n = n + 1) begin
        @(posedge clk);
        if (arr) arv <= 1'b0;
        if (n > 50) tmo;
      end
      d = rdat;
      rsp = rr;
      rrdy <= 1'b0;
    end
  endtask
  task setr(input [3:0] i, input [7:0] v);
    begin
      wr(`MAFD_OFS_REGSEL, {28'h0, i});
      wr(`MAFD_OFS_REGDATA, {24'h0, v});
    end
  endtask
  task chkr(input [3:0] i, input [7:0] v);
    begin
      wr(`MAFD_OFS_REGSEL, {28'h0, i});
      rd(`MAFD_OFS_REGDATA);
      chk("register", {24'h0, v}, d);
    end
  endtask
  // Polling status keeps each launch apart, as only one instruction may run at a time.
  task run(input [2:0] op, input [4:0] s, input [2:0] rl, input [4:0] ds);
    integer n;
    begin
      wr(`MAFD_OFS_INSTR, {16'h0, op, s, rl, ds});
      d = 32'h1;
      for (n = 0; d[0]; n = n + 1) begin
        if (n > 20) tmo;
        rd(`MAFD_OFS_STATUS);
      end
    end
  endtask
  task pre(input [7:0] l, input [7:0] r);
    begin
      @(posedge clk);
      lv <= l;
      rv <= r;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
    end
  endtask
  function [7:0] ror(input [7:0] v, input [2:0] n);
    ror = (v >> n) | (v << (4'd8 - n));
  endfunction
  function [7:0] mrg(input [7:0] b, input [7:0] v, input [2:0] len, input [2:0] off);
    reg [7:0] m;
    begin
      m = (len == 3'd0) ? 8'hFF : ((8'h01 << len) - 8'h01);
      mrg = (b & ~(m << off)) | ((v & m) << off);
    end
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    begin
      rd(`MAFD_OFS_STATUS);
      chk("status", 32'h0, d);
      chk("status resp", {30'h0, `MAFD_RESP_OKAY}, {30'h0, rsp});
      chkr(4'h7, 8'h00);
      wr(5'h14, 32'h000000FF);
      chk("unmapped wresp", {30'h0, `MAFD_RESP_SLVERR}, {30'h0, rsp});
      wr(`MAFD_OFS_REGSEL, 32'h00000007);
      chk("mapped wresp", {30'h0, `MAFD_RESP_OKAY}, {30'h0, rsp});
      rd(5'h14);
      chk("unmapped resp", {30'h0, `MAFD_RESP_SLVERR}, {30'h0, rsp});
      chk("unmapped data", 32'h0, d);
    end
  endtask
  task t_rr;
    integer r;
    begin
      setr(4'h1, 8'hB4);
      for (r = 0; r < 8; r = r + 1) begin
        run(3'h0, 5'h01, r[2:0], 5'h02);
        chkr(4'h2, ror(8'hB4, r[2:0]));
        chkr(4'h1, 8'hB4);
      end
    end
  endtask
  task t_addr;
    begin
      setr(4'h3, 8'h5A);
      run(3'h0, 5'h03, 3'h1, 5'h07);
      chk("address", {3'b101, 8'h2D}, cap);
      chkr(4'h7, 8'h2D);
      run(3'h0, 5'h03, 3'h2, 5'h0F);
      chk("address", {3'b110, 8'h96}, cap);
      chkr(4'hF, 8'h96);
    end
  endtask
  task t_bus;
    begin
      pre(8'hF0, 8'h3C);
      setr(4'h5, 8'hAB);
      run(3'h0, 5'h05, 3'h3, 5'h14);
      chk("left port", mrg(8'hF0, 8'hAB, 3'h3, 3'h4), lp);
      chk("right port", 8'h3C, rp);
      run(3'h0, 5'h05, 3'h0, 5'h18);
      chk("right port", 8'hAB, rp);
      chkr(4'h5, 8'hAB);
      pre(8'h11, 8'hC6);
      run(3'h0, 5'h1A, 3'h3, 5'h04);
      chkr(4'h4, ror(8'hC6, 3'h2) & 8'h07);
      run(3'h0, 5'h12, 3'h0, 5'h04);
      chkr(4'h4, ror(8'h11, 3'h2));
      pre(8'h3C, 8'h99);
      run(3'h0, 5'h11, 3'h2, 5'h13);
      chk("left port", mrg(8'h3C, ror(8'h3C, 3'h1), 3'h2, 3'h3), lp);
      // The low bits below the offset show whose data formed the merge base.
      pre(8'h3D, 8'h9A);
      run(3'h0, 5'h11, 3'h2, 5'h1A);
      chk("right port", mrg(8'h3D, ror(8'h3D, 3'h1), 3'h0, 3'h2), rp);
      pre(8'h00, 8'hA5);
      run(3'h0, 5'h1C, 3'h3, 5'h07);
      chk("address", {3'b101, ror(8'hA5, 3'h4) & 8'h07}, cap);
      chkr(4'h7, ror(8'hA5, 3'h4) & 8'h07);
    end
  endtask
  task t_add;
    begin
      setr(4'h0, 8'hF0);
      setr(4'h1, 8'h21);
      run(3'h1, 5'h01, 3'h0, 5'h02);
      chk("overflow status", 32'h2, d);
      chkr(4'h2, 8'h11);
      chkr(4'h8, 8'h01);
      setr(4'h1, 8'h02);
      run(3'h1, 5'h01, 3'h1, 5'h02);
      chkr(4'h2, 8'hF1);
      chkr(4'h8, 8'h00);
      chkr(4'h0, 8'hF0);
      chkr(4'h1, 8'h02);
      run(3'h2, 5'h01, 3'h0, 5'h02);
      chk("bad opcode status", 32'h4, d);
      chkr(4'h2, 8'hF1);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_rr;
    t_addr;
    t_bus;
    t_add;
    stop_test;
  end
endmodule // move_add_field_datapath_tb_top
